// File: serial_pkg.sv
// Constants, register map and carrier types for the serial port register block.
//
// How it works
// - Timer source selected: the divisor is ignored for bit timing.
// - Power-down entry halts the port but keeps the baud divisor.
// - Status: parity, framing, overrun at 7..5, bit 4 zero, busy/full at 3..0.
// - Transmit full sets on a buffer write, clears after the transmit request.
// - Receive busy reads one only while a frame is being received.
// - Transmit busy reads one only while a frame is being sent.
// - Receive full reads one while the receive buffer holds a byte.
// - Power-down entry clears every status bit and stops the port.
// - Receive buffer is undefined after power-down; software reads it first.
// - Transmit buffer need not survive power-down.
// - Receive and transmit buffers share one address: read receives, write transmits.
// - Clock gate enable low keeps the port inert; high restores it.
// - Clock gate enable resets to zero; software sets it before first use.
// - A write to a locked control bit silently keeps the old value.
// - Transmit stop length changes only with transmit enable and busy both zero.
// - Parity bits change only with all enables and busy flags zero.
// - Infrared output select changes only with transmit enable and busy zero.
// - Noise time and receive stop length change only with receive side idle.
// - Power-down entry clears both enables; other control bits hold.
package serial_pkg;

  localparam int ADDR_W = 14;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_CONTROL_ONE = 12'h01A;
  localparam logic [11:0] IDX_CONTROL_TWO = 12'h01B;
  localparam logic [11:0] IDX_BAUD_DIVISOR = 12'h01C;
  localparam logic [11:0] IDX_SERIAL_STATUS = 12'h01D;
  localparam logic [11:0] IDX_DATA_BYTE = 12'h01E;
  localparam logic [11:0] IDX_POWER_CONTROL = 12'hF75;

  // Control one fields.
  localparam int C1_TX_EN = 7;
  localparam int C1_RX_EN = 6;
  localparam int C1_STOP_TX = 5;
  localparam int C1_EVEN = 4;
  localparam int C1_PARITY_ADD = 3;
  localparam int C1_IRDA = 2;
  localparam int C1_TIMER_SRC = 1;

  // Control two fields.
  localparam int C2_SAMPLE_LSB = 3;
  localparam int C2_NOISE_LSB = 1;
  localparam int C2_STOP_RX = 0;

  // Status fields.
  localparam int ST_PARITY = 7;
  localparam int ST_FRAMING = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_RX_BUSY = 3;
  localparam int ST_RX_FULL = 2;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_TX_FULL = 0;

  localparam int PWR_GATE = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Settings handed to the frame engine.
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic stop_tx;
    logic parity_even;
    logic parity_add;
    logic irda_sel;
    logic timer_src;
    logic [2:0] sample_count;
    logic [1:0] noise_time;
    logic stop_rx;
    logic [7:0] divisor;
  } engine_cfg_t;

  // Events and levels reported by the frame engine.
  typedef struct packed {
    logic rx_busy;
    logic tx_busy;
    logic rx_done;
    logic [7:0] rx_byte;
    logic parity_err;
    logic framing_err;
    logic tx_irq;
  } engine_evt_t;

endpackage

// File: serial_regs.sv
// Register block of the serial port: AXI4-Lite slave, status flags, buffers and write protection.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module serial_regs
  import serial_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_down_entry,
  input wire engine_evt_t engine_evt,
  output engine_cfg_t engine_cfg,
  output logic clock_gate_enable,
  output logic [7:0] transmit_byte,
  output logic transmit_pending
);

  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] aw_idx_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic [7:0] control_one_reg;
  logic [5:0] control_two_reg;
  logic [7:0] baud_divisor_reg;
  logic [7:0] divisor_used_reg;
  logic gate_reg;
  logic [7:0] receive_byte_reg;
  logic [7:0] transmit_byte_reg;
  logic parity_error_flag_reg;
  logic framing_error_flag_reg;
  logic overrun_error_flag_reg;
  logic rx_busy_reg;
  logic receive_full_flag_reg;
  logic tx_busy_reg;
  logic transmit_full_flag_reg;
  logic write_go;
  logic [11:0] ar_idx;
  logic read_go;
  logic rx_read;
  logic tx_write;
  logic tx_lock;
  logic rx_lock;
  logic rx_done;
  logic [7:0] status_byte;
  logic [7:0] read_byte;
  logic read_hit;
  logic write_hit;

  assign write_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];
  assign read_go = s_axi_arvalid && s_axi_arready;
  assign rx_read = read_go && (ar_idx == IDX_DATA_BYTE);
  assign tx_write = write_go && w_lane_reg && (aw_idx_reg == IDX_DATA_BYTE);
  assign tx_lock = control_one_reg[C1_TX_EN] || tx_busy_reg;
  assign rx_lock = control_one_reg[C1_RX_EN] || rx_busy_reg;
  // Engine events count only while the port has its clock.
  assign rx_done = gate_reg && engine_evt.rx_done;

  always_comb
  begin
    status_byte = {parity_error_flag_reg, framing_error_flag_reg, overrun_error_flag_reg, 1'b0,
                   rx_busy_reg, receive_full_flag_reg, tx_busy_reg, transmit_full_flag_reg};
    read_hit = 1'b1;
    case (ar_idx)
      IDX_CONTROL_ONE: read_byte = {control_one_reg[7:1], 1'b0};
      IDX_CONTROL_TWO: read_byte = {2'h0, control_two_reg};
      IDX_BAUD_DIVISOR: read_byte = baud_divisor_reg;
      IDX_SERIAL_STATUS: read_byte = status_byte;
      IDX_DATA_BYTE: read_byte = receive_byte_reg;
      IDX_POWER_CONTROL: read_byte = {7'h00, gate_reg};
      default:
      begin
        read_byte = 8'h00;
        read_hit = 1'b0;
      end
    endcase
    case (aw_idx_reg)
      IDX_CONTROL_ONE, IDX_CONTROL_TWO, IDX_BAUD_DIVISOR,
      IDX_SERIAL_STATUS, IDX_DATA_BYTE, IDX_POWER_CONTROL: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  // Write address and data are taken in either order and held until the response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 12'h000;
      w_byte_reg <= RESET_BYTE;
      w_lane_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready;
      s_axi_wready <= !w_held_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (write_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b0 : (!s_axi_rvalid && !s_axi_arready);
      if (read_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, read_byte};
        s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Clock gate enable; its reset value keeps the port inert until software wakes it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gate_reg <= 1'b0;
    end
    else if (write_go && w_lane_reg && aw_idx_reg == IDX_POWER_CONTROL)
    begin
      gate_reg <= w_byte_reg[PWR_GATE];
    end
  end

  // Control one: enables writable unless power-down entry is high, frame settings only while idle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_one_reg <= RESET_BYTE;
    end
    else if (power_down_entry)
    begin
      control_one_reg[C1_TX_EN] <= 1'b0;
      control_one_reg[C1_RX_EN] <= 1'b0;
    end
    else if (write_go && w_lane_reg && aw_idx_reg == IDX_CONTROL_ONE)
    begin
      control_one_reg[C1_TX_EN] <= w_byte_reg[C1_TX_EN];
      control_one_reg[C1_RX_EN] <= w_byte_reg[C1_RX_EN];
      if (!tx_lock)
      begin
        control_one_reg[C1_STOP_TX] <= w_byte_reg[C1_STOP_TX];
        control_one_reg[C1_IRDA] <= w_byte_reg[C1_IRDA];
      end
      if (!tx_lock && !rx_lock)
      begin
        control_one_reg[C1_EVEN] <= w_byte_reg[C1_EVEN];
        control_one_reg[C1_PARITY_ADD] <= w_byte_reg[C1_PARITY_ADD];
        control_one_reg[C1_TIMER_SRC] <= w_byte_reg[C1_TIMER_SRC];
      end
    end
  end

  // Control two holds its value across power-down entry.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_two_reg <= 6'h00;
    end
    else if (write_go && w_lane_reg && aw_idx_reg == IDX_CONTROL_TWO)
    begin
      if (!tx_lock && !rx_lock)
      begin
        control_two_reg[C2_SAMPLE_LSB +: 3] <= w_byte_reg[C2_SAMPLE_LSB +: 3];
      end
      if (!rx_lock)
      begin
        control_two_reg[C2_NOISE_LSB +: 2] <= w_byte_reg[C2_NOISE_LSB +: 2];
        control_two_reg[C2_STOP_RX] <= w_byte_reg[C2_STOP_RX];
      end
    end
  end

  // Baud divisor is never touched by power-down entry; software keeps enables low while writing.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      baud_divisor_reg <= RESET_BYTE;
      divisor_used_reg <= RESET_BYTE;
    end
    else
    begin
      if (write_go && w_lane_reg && aw_idx_reg == IDX_BAUD_DIVISOR)
      begin
        baud_divisor_reg <= w_byte_reg;
      end
      divisor_used_reg <= control_one_reg[C1_TIMER_SRC] ? RESET_BYTE : baud_divisor_reg;
    end
  end

  // Buffers; their contents are left as they are at power-down since they become undefined.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      receive_byte_reg <= RESET_BYTE;
      transmit_byte_reg <= RESET_BYTE;
    end
    else
    begin
      if (rx_done)
      begin
        receive_byte_reg <= engine_evt.rx_byte;
      end
      if (tx_write)
      begin
        transmit_byte_reg <= w_byte_reg;
      end
    end
  end

  // Status flags: hardware set wins over a clear in the same cycle, power-down wins over all.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || power_down_entry)
    begin
      parity_error_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0;
      rx_busy_reg <= 1'b0;
      receive_full_flag_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      transmit_full_flag_reg <= 1'b0;
    end
    else
    begin
      rx_busy_reg <= gate_reg && engine_evt.rx_busy;
      tx_busy_reg <= gate_reg && engine_evt.tx_busy;
      if (rx_done)
      begin
        receive_full_flag_reg <= 1'b1;
        parity_error_flag_reg <= engine_evt.parity_err;
        framing_error_flag_reg <= engine_evt.framing_err;
        overrun_error_flag_reg <= receive_full_flag_reg && !rx_read;
      end
      else if (rx_read)
      begin
        receive_full_flag_reg <= 1'b0;
        parity_error_flag_reg <= 1'b0;
        framing_error_flag_reg <= 1'b0;
        overrun_error_flag_reg <= 1'b0;
      end
      if (tx_write)
      begin
        transmit_full_flag_reg <= 1'b1;
      end
      else if (gate_reg && engine_evt.tx_irq)
      begin
        transmit_full_flag_reg <= 1'b0;
      end
    end
  end

  // Engine-facing outputs, all registered.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      engine_cfg <= '0;
      clock_gate_enable <= 1'b0;
      transmit_byte <= RESET_BYTE;
      transmit_pending <= 1'b0;
    end
    else
    begin
      engine_cfg.tx_en <= control_one_reg[C1_TX_EN] && gate_reg;
      engine_cfg.rx_en <= control_one_reg[C1_RX_EN] && gate_reg;
      engine_cfg.stop_tx <= control_one_reg[C1_STOP_TX];
      engine_cfg.parity_even <= control_one_reg[C1_EVEN];
      engine_cfg.parity_add <= control_one_reg[C1_PARITY_ADD];
      engine_cfg.irda_sel <= control_one_reg[C1_IRDA];
      engine_cfg.timer_src <= control_one_reg[C1_TIMER_SRC];
      engine_cfg.sample_count <= control_two_reg[C2_SAMPLE_LSB +: 3];
      engine_cfg.noise_time <= control_two_reg[C2_NOISE_LSB +: 2];
      engine_cfg.stop_rx <= control_two_reg[C2_STOP_RX];
      engine_cfg.divisor <= divisor_used_reg;
      clock_gate_enable <= gate_reg;
      transmit_byte <= transmit_byte_reg;
      transmit_pending <= transmit_full_flag_reg && gate_reg && !power_down_entry;
    end
  end

endmodule

// File: serial_chk.sv
// Concurrent checks on the serial register block ports.
`timescale 1ns/1ps
module serial_chk
  import serial_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic power_down_entry,
  input wire engine_cfg_t engine_cfg,
  input wire logic clock_gate_enable,
  input wire logic transmit_pending
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  pd_enable_a: assert property (power_down_entry |-> ##2 !(engine_cfg.tx_en || engine_cfg.rx_en))
    else $error("enables survive power down");
  pd_pending_a: assert property (power_down_entry |-> ##2 !transmit_pending)
    else $error("transmit full survives power down");
  gate_off_a: assert property (!clock_gate_enable |->
    !(engine_cfg.tx_en || engine_cfg.rx_en || transmit_pending))
    else $error("port active with gate off");
  timer_div_a: assert property (engine_cfg.timer_src [*3] |-> engine_cfg.divisor == 8'h00)
    else $error("divisor used with timer source");
  tx_lock_a: assert property (engine_cfg.tx_en |=> $stable({engine_cfg.stop_tx, engine_cfg.irda_sel}))
    else $error("transmit setting changed while enabled");
  par_lock_a: assert property (engine_cfg.tx_en || engine_cfg.rx_en |=>
    $stable({engine_cfg.parity_even, engine_cfg.parity_add, engine_cfg.timer_src, engine_cfg.sample_count}))
    else $error("shared setting changed while enabled");
  rx_lock_a: assert property (engine_cfg.rx_en |=> $stable({engine_cfg.noise_time, engine_cfg.stop_rx}))
    else $error("receive setting changed while enabled");
endmodule

// File: engine_model.sv
// Frame engine and remote serial device model that feeds the register block.
`timescale 1ns/1ps
module engine_model
  import serial_pkg::*;
#(parameter int FRAME = 60)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire engine_cfg_t engine_cfg,
  input wire logic transmit_pending,
  input wire logic rx_go,
  input wire logic [9:0] rx_word,
  output engine_evt_t engine_evt
);
  int tx_cnt;
  int rx_cnt;
  logic [9:0] rx_hold;
  always_ff @(posedge aclk)
  begin
    engine_evt.tx_irq <= 1'b0;
    engine_evt.rx_done <= 1'b0;
    // Outside a frame the byte lines carry no data, so they keep changing.
    engine_evt.rx_byte <= ~engine_evt.rx_byte;
    if (!aresetn)
    begin
      engine_evt <= '0;
      tx_cnt <= 0;
      rx_cnt <= 0;
    end
    else
    begin
      if (tx_cnt > 0)
        tx_cnt <= tx_cnt - 1;
      else if (transmit_pending && engine_cfg.tx_en)
        tx_cnt <= FRAME;
      engine_evt.tx_irq <= tx_cnt == FRAME - 8;
      engine_evt.tx_busy <= tx_cnt > 0 && tx_cnt <= FRAME - 8;
      if (rx_cnt > 0)
        rx_cnt <= rx_cnt - 1;
      else if (rx_go && engine_cfg.rx_en)
      begin
        rx_cnt <= FRAME;
        rx_hold <= rx_word;
      end
      engine_evt.rx_busy <= rx_cnt > 1;
      if (rx_cnt == 1)
      begin
        engine_evt.rx_done <= 1'b1;
        engine_evt.rx_byte <= rx_hold[7:0];
        {engine_evt.parity_err, engine_evt.framing_err} <= rx_hold[9:8];
      end
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the serial port register block.
`timescale 1ns/1ps
module testbench;
  import serial_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  logic power_down_entry = 1'b0;
  engine_evt_t engine_evt;
  engine_cfg_t engine_cfg;
  logic clock_gate_enable;
  logic [7:0] transmit_byte;
  logic transmit_pending;
  logic rx_go = 1'b0;
  logic [9:0] rx_word = '0;
  logic [31:0] lfsr = 32'h051F33A5;
  logic [31:0] rdat;
  logic [1:0] rrsp;
  logic [7:0] c1m = 8'h00;
  logic [7:0] c2m = 8'h00;
  logic [7:0] dv;
  logic busy_tx = 1'b0;
  logic [11:0] map [6] = '{IDX_CONTROL_ONE, IDX_CONTROL_TWO, IDX_BAUD_DIVISOR, IDX_SERIAL_STATUS,
    IDX_DATA_BYTE, IDX_POWER_CONTROL};
  int err_count = 0;
  int total_checks = 0;
  always #25 aclk = ~aclk;
  serial_regs i_serial_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_down_entry, .engine_evt, .engine_cfg, .clock_gate_enable, .transmit_byte, .transmit_pending);
  engine_model i_engine_model (.aclk, .aresetn, .engine_cfg, .transmit_pending, .rx_go, .rx_word, .engine_evt);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected control byte after a write; lock state is taken from before the write.
  function automatic logic [7:0] lk(input logic two, input logic [7:0] o, input logic [7:0] n);
    logic t;
    logic r;
    logic [7:0] m;
    t = !c1m[7] && !busy_tx;
    r = !c1m[6];
    m = two ? {2'b00, {3{t && r}}, {3{r}}}
      : {2'b11, t, {2{t && r}}, t, t && r, 1'b0};
    return (o & ~m) | (n & m);
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 60);
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    if (!s_axi_bvalid)
      close_out();
  endtask
  task automatic rd(input logic [11:0] idx);
    int n;
    n = 0;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 60);
    chk(s_axi_rvalid, 1'b1);
    if (!s_axi_rvalid)
      close_out();
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    rd(idx);
    chk({rrsp, rdat}, {RESP_OKAY, 24'h0, exp});
  endtask
  task automatic wc(input logic two, input logic [7:0] n);
    if (two)
      c2m = lk(1'b1, c2m, n);
    else
      c1m = lk(1'b0, c1m, n);
    wr(two ? IDX_CONTROL_TWO : IDX_CONTROL_ONE, n, RESP_OKAY);
    rdc(two ? IDX_CONTROL_TWO : IDX_CONTROL_ONE, two ? c2m : c1m);
  endtask
  task automatic wait_st(input logic [7:0] mask, input logic [7:0] val);
    int n;
    n = 0;
    do
    begin
      rd(IDX_SERIAL_STATUS);
      n++;
    end
    while ((rdat[7:0] & mask) != val && n < 40);
    chk(rdat[7:0] & mask, val);
    // A status that never arrives ends the run here rather than letting later checks drift.
    if ((rdat[7:0] & mask) != val)
      close_out();
  endtask
  task automatic rx_frame(input logic [9:0] w);
    rx_word <= w;
    rx_go <= 1'b1;
    @(posedge aclk);
    rx_go <= 1'b0;
    wait_st(8'h08, 8'h08);
    chk(rdat[3], 1'b1);
    wait_st(8'h08, 8'h00);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    foreach (map[i])
      rdc(map[i], 8'h00);
    wc(1'b0, 8'hC0);
    tick(3);
    chk({clock_gate_enable, engine_cfg.tx_en, engine_cfg.rx_en}, 3'b000);
    // The gate stays on from here, since dropping it mid-transfer upsets the port.
    wr(IDX_POWER_CONTROL, 8'h01, RESP_OKAY);
    tick(3);
    chk({clock_gate_enable, engine_cfg.tx_en}, 2'b11);
    $display("gate test done");
    wc(1'b0, 8'h00);
    lfsr = nxt(lfsr);
    dv = lfsr[7:0];
    wr(IDX_BAUD_DIVISOR, dv, RESP_OKAY);
    rdc(IDX_BAUD_DIVISOR, dv);
    wc(1'b0, 8'h02);
    tick(4);
    chk(engine_cfg.divisor, 8'h00);
    wc(1'b0, 8'h00);
    tick(4);
    chk(engine_cfg.divisor, dv);
    repeat (16)
    begin
      lfsr = nxt(lfsr);
      wc(lfsr[8], lfsr[8] ? lfsr[7:0] & 8'h1F : lfsr[7:0]);
    end
    chk({engine_cfg.tx_en, engine_cfg.rx_en, engine_cfg.stop_tx, engine_cfg.parity_even,
      engine_cfg.parity_add, engine_cfg.irda_sel, engine_cfg.timer_src, engine_cfg.sample_count,
      engine_cfg.noise_time, engine_cfg.stop_rx, engine_cfg.divisor}, {c1m[7:1], c2m[5:0], (c1m[1] ? 8'h00 : dv)});
    $display("divisor and lock test done");
    wc(1'b0, 8'h00);
    wc(1'b0, 8'h80);
    lfsr = nxt(lfsr);
    wr(IDX_DATA_BYTE, lfsr[7:0], RESP_OKAY);
    tick(1);
    chk({transmit_pending, transmit_byte}, {1'b1, lfsr[7:0]});
    rdc(IDX_SERIAL_STATUS, 8'h01);
    wait_st(8'h03, 8'h02);
    chk(rdat, 32'h2);
    busy_tx = 1'b1;
    wc(1'b0, 8'h00);
    wc(1'b0, 8'h20);
    wait_st(8'h02, 8'h00);
    busy_tx = 1'b0;
    chk(rdat, 32'h0);
    wc(1'b0, 8'h20);
    $display("transmit test done");
    wc(1'b0, 8'h40);
    for (int e = 0; e < 4; e++)
    begin
      lfsr = nxt(lfsr);
      rx_frame({e[1:0], lfsr[7:0]});
      rdc(IDX_SERIAL_STATUS, {e[1:0], 6'h04});
      rdc(IDX_DATA_BYTE, lfsr[7:0]);
      rdc(IDX_SERIAL_STATUS, 8'h00);
    end
    rx_frame(10'h0A5);
    rx_frame(10'h05A);
    wr(IDX_SERIAL_STATUS, 8'hFF, RESP_OKAY);
    // A write with the low lane disabled must leave the transmit buffer and its flag alone.
    s_axi_wstrb <= 4'h0;
    wr(IDX_DATA_BYTE, 8'h3C, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdc(IDX_SERIAL_STATUS, 8'h24);
    wr(12'h050, 8'h11, RESP_SLVERR);
    rd(12'h050);
    chk({rrsp, rdat}, {RESP_SLVERR, 32'h0});
    $display("receive test done");
    power_down_entry <= 1'b1;
    @(posedge aclk);
    power_down_entry <= 1'b0;
    rdc(IDX_SERIAL_STATUS, 8'h00);
    rdc(IDX_BAUD_DIVISOR, dv);
    rdc(IDX_CONTROL_ONE, c1m & 8'h3F);
    rdc(IDX_CONTROL_TWO, c2m);
    $display("power down test done");
    close_out();
  end
endmodule
bind serial_regs serial_chk i_serial_chk (.aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid, .power_down_entry,
  .engine_cfg, .clock_gate_enable, .transmit_pending);
